// [ecl_pkg.sv]
// Constants shared by the configuration image loader.
// Assumes one 50 MHz clock domain and a byte-wide EEPROM read engine.
package ecl_pkg;
    // ========================================
    // Image layout
    localparam logic [7:0] ECL_HDR_ADDR = 8'h00;
    localparam logic [7:0] ECL_HDR_LEN = 8'h03;
    localparam int ECL_BIT_CRC = 7;
    localparam int ECL_BIT_MAP = 6;
    localparam int ECL_BIT_BIG = 5;
    localparam int ECL_BIT_COM = 4;
    localparam logic [7:0] ECL_IDX_BASE = 8'h03;
    localparam logic [7:0] ECL_ENT2_LEN = 8'h02;
    localparam logic [7:0] ECL_ENT3_LEN = 8'h03;
    localparam logic [7:0] ECL_DATA2 = 8'h83;
    localparam logic [7:0] ECL_DATA3 = 8'hC3;
    localparam logic [7:0] ECL_PAGE_LEN = 8'h04;
    localparam logic [6:0] ECL_SA_MIN = 7'h18;
    localparam logic [6:0] ECL_SA_MAX = 7'h27;
    localparam logic [7:0] ECL_CRC_POLY = 8'h07;
    localparam logic [7:0] ECL_CRC_INIT = 8'h00;
    // ========================================
    // Register map and reset values
    localparam logic [7:0] ECL_REG_CTRL = 8'h00;
    localparam logic [7:0] ECL_REG_STAT = 8'h04;
    localparam logic [7:0] ECL_REG_HDR = 8'h08;
    localparam logic [7:0] ECL_REG_CH0 = 8'h10;
    localparam logic [7:0] ECL_REG_CH1 = 8'h14;
    localparam logic [7:0] ECL_REG_CH2 = 8'h18;
    localparam logic [7:0] ECL_REG_CH3 = 8'h1C;
    localparam int ECL_CTRL_GO = 0;
    localparam int ECL_CTRL_SA_LSB = 8;
    localparam logic [6:0] ECL_SA_RST = 7'h18;
    localparam logic ECL_GO_RST = 1'b1;
    // ========================================
    // Sequencer states and read phases
    typedef enum logic [2:0] {
        ECL_S_IDLE = 3'b000,
        ECL_S_REQ = 3'b001,
        ECL_S_WAIT = 3'b010,
        ECL_S_NEXT = 3'b011,
        ECL_S_CHAN = 3'b100,
        ECL_S_APPLY = 3'b101
    } ecl_state_t;
    typedef enum logic [1:0] {
        ECL_PH_HDR = 2'b00,
        ECL_PH_ENT = 2'b01,
        ECL_PH_DAT = 2'b10
    } ecl_phase_t;
endpackage

// [ecl_loader.sv]
// Configuration image loader: walks an EEPROM image and applies channel pages.
// Assumes a same-clock EEPROM engine that returns eep_len bytes per request.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Three header bytes at addresses 0..2 are read first as global setup.
// - Header bits 7 and 6 both set: check per-page CRC; otherwise no CRC check at all.
// - Header bit 6 set: use slot index; clear: data follows header directly.
// - Header bit 4 set: one page for all channels; clear: page per channel.
// - Device count bits 3:0 hold devices minus one and are ignored.
// - Each EEPROM burst after the 3-byte header read is limited to header byte 2 bytes, or one byte when that byte is zero.
// - A channel page is 4 bytes; slot is 16 bytes or 4 when shared.
// - Index byte 0 holds the 8-bit CRC for that entry's channel page.
// - Index byte 1 is the start address of the page data.
// - Index reserves 16 devices of four channels: 128 or 192 bytes.
// - Address 0x18 device reads entries 0x03..0x0A, channels ascending.
// - Slot address 0x18..0x27 picks 8-byte or 12-byte blocks from 0x03.
// - Indexed data starts at 0x83 for 2-byte or 0xC3 for 3-byte entries.
// - CRC-8 runs over header, index entry bytes after byte 0 and page data bytes.
module ecl_loader import ecl_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic eep_req,
    output logic [7:0] eep_addr,
    output logic [7:0] eep_len,
    input wire logic eep_rvalid,
    input wire logic [7:0] eep_rdata,
    input wire logic eep_err,
    output logic [31:0] cfg_ch0,
    output logic [31:0] cfg_ch1,
    output logic [31:0] cfg_ch2,
    output logic [31:0] cfg_ch3,
    output logic cfg_apply,
    output logic load_busy
);
    // ========================================
    // CRC-8 step, MSB first
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ ECL_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    ecl_state_t st_q;
    ecl_phase_t ph_q;
    logic [7:0] rd_addr_q, rd_left_q, bst_left_q;
    logic [7:0] hdr0_q, hdr1_q, hdr2_q;
    logic [1:0] ch_q, idx_q;
    logic [7:0] crc_q, hcrc_q, crc_exp_q, start_q;
    logic [31:0] page_q;
    logic [31:0] shadow_q [4];
    logic [6:0] sa_q;
    logic go_q, done_q, crc_err_q, ext_err_q, slot_err_q;

    // ========================================
    // Image geometry
    wire logic crc_en = hdr0_q[ECL_BIT_CRC];
    wire logic map_en = hdr0_q[ECL_BIT_MAP];
    wire logic big_img = hdr0_q[ECL_BIT_BIG];
    wire logic com_en = hdr0_q[ECL_BIT_COM];
    wire logic [7:0] ent_len = big_img ? ECL_ENT3_LEN : ECL_ENT2_LEN;
    wire logic [7:0] data_min = big_img ? ECL_DATA3 : ECL_DATA2;
    wire logic [7:0] slot = {4'h0, 4'(sa_q - ECL_SA_MIN)};
    wire logic [7:0] ch8 = {6'h00, ch_q};
    // Block stride is 8 or 12 bytes per slot, entry stride 2 or 3 per channel
    wire logic [7:0] blk_off = big_img ? 8'((slot << 3) + (slot << 2)) : 8'(slot << 3);
    wire logic [7:0] ent_off = big_img ? 8'((ch8 << 1) + ch8) : 8'(ch8 << 1);
    wire logic [7:0] ent_addr = 8'(ECL_IDX_BASE + blk_off + ent_off);
    wire logic [7:0] raw_addr = 8'(ECL_HDR_LEN + (ch8 << 2));
    wire logic slot_ok = (sa_q >= ECL_SA_MIN) && (sa_q <= ECL_SA_MAX);
    // A zero burst size would stall the engine, so it is read as one byte
    wire logic [7:0] bst_max = (ph_q == ECL_PH_HDR) ? ECL_HDR_LEN :
        ((hdr2_q == 8'h00) ? 8'h01 : hdr2_q);
    wire logic [7:0] bst_len = (rd_left_q < bst_max) ? rd_left_q : bst_max;
    wire logic crc_bad = crc_en && map_en && (crc_q != crc_exp_q);
    wire logic last_ch = com_en || (ch_q == 2'd3);
    wire logic [7:0] crc_nx = crc8(crc_q, eep_rdata);

    // ========================================
    // Wishbone slave
    wire logic wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr_ctrl = wb_hit && wb_we_i && (wb_adr_i == ECL_REG_CTRL);
    wire logic go_wr = wr_ctrl && wb_sel_i[0] && wb_dat_i[ECL_CTRL_GO];
    wire logic sa_wr = wr_ctrl && wb_sel_i[1] && (st_q == ECL_S_IDLE);
    wire logic [31:0] stat_w = {27'h0, slot_err_q, ext_err_q, crc_err_q, done_q, load_busy};
    wire logic [31:0] rd_mux =
        (wb_adr_i == ECL_REG_CTRL) ? {17'h0, sa_q, 7'h0, go_q} :
        (wb_adr_i == ECL_REG_STAT) ? stat_w :
        (wb_adr_i == ECL_REG_HDR) ? {8'h00, hdr2_q, hdr1_q, hdr0_q} :
        (wb_adr_i == ECL_REG_CH0) ? cfg_ch0 :
        (wb_adr_i == ECL_REG_CH1) ? cfg_ch1 :
        (wb_adr_i == ECL_REG_CH2) ? cfg_ch2 :
        (wb_adr_i == ECL_REG_CH3) ? cfg_ch3 : 32'h0000_0000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            sa_q <= ECL_SA_RST;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0000_0000;
            if (sa_wr) begin
                sa_q <= wb_dat_i[ECL_CTRL_SA_LSB +: 7];
            end
        end
    end

    // ========================================
    // Load sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ECL_S_IDLE;
            ph_q <= ECL_PH_HDR;
            go_q <= ECL_GO_RST;
            rd_addr_q <= 8'h00;
            rd_left_q <= 8'h00;
            bst_left_q <= 8'h00;
            hdr0_q <= 8'h00;
            hdr1_q <= 8'h00;
            hdr2_q <= 8'h00;
            ch_q <= 2'd0;
            idx_q <= 2'd0;
            crc_q <= ECL_CRC_INIT;
            hcrc_q <= ECL_CRC_INIT;
            crc_exp_q <= 8'h00;
            start_q <= 8'h00;
            page_q <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                shadow_q[i] <= 32'h0000_0000;
            end
            eep_req <= 1'b0;
            eep_addr <= 8'h00;
            eep_len <= 8'h00;
            cfg_ch0 <= 32'h0000_0000;
            cfg_ch1 <= 32'h0000_0000;
            cfg_ch2 <= 32'h0000_0000;
            cfg_ch3 <= 32'h0000_0000;
            cfg_apply <= 1'b0;
            load_busy <= 1'b0;
            done_q <= 1'b0;
            crc_err_q <= 1'b0;
            ext_err_q <= 1'b0;
            slot_err_q <= 1'b0;
        end else begin
            eep_req <= 1'b0;
            cfg_apply <= 1'b0;
            if (go_wr) begin
                go_q <= 1'b1;
            end
            case (st_q)
                ECL_S_IDLE: begin
                    if (go_q) begin
                        // Power-up load and software start share this path
                        go_q <= go_wr;
                        load_busy <= 1'b1;
                        done_q <= 1'b0;
                        crc_err_q <= 1'b0;
                        ext_err_q <= 1'b0;
                        slot_err_q <= 1'b0;
                        ph_q <= ECL_PH_HDR;
                        rd_addr_q <= ECL_HDR_ADDR;
                        rd_left_q <= ECL_HDR_LEN;
                        idx_q <= 2'd0;
                        crc_q <= ECL_CRC_INIT;
                        st_q <= ECL_S_REQ;
                    end
                end
                ECL_S_REQ: begin
                    eep_req <= 1'b1;
                    eep_addr <= rd_addr_q;
                    eep_len <= bst_len;
                    bst_left_q <= bst_len;
                    st_q <= ECL_S_WAIT;
                end
                ECL_S_WAIT: begin
                    if (eep_err) begin
                        ext_err_q <= 1'b1;
                        load_busy <= 1'b0;
                        st_q <= ECL_S_IDLE;
                    end else if (eep_rvalid) begin
                        idx_q <= idx_q + 2'd1;
                        rd_addr_q <= rd_addr_q + 8'h01;
                        rd_left_q <= rd_left_q - 8'h01;
                        bst_left_q <= bst_left_q - 8'h01;
                        // Byte 0 of an entry is the expected CRC, never part of the sum
                        if (!(ph_q == ECL_PH_ENT && idx_q == 2'd0)) begin
                            crc_q <= crc_nx;
                        end
                        case (ph_q)
                            ECL_PH_HDR: begin
                                // Device count bits are kept for software only
                                if (idx_q == 2'd0) hdr0_q <= eep_rdata;
                                if (idx_q == 2'd1) hdr1_q <= eep_rdata;
                                if (idx_q == 2'd2) hdr2_q <= eep_rdata;
                            end
                            ECL_PH_ENT: begin
                                if (idx_q == 2'd0) crc_exp_q <= eep_rdata;
                                // Upper start bits are not supported and dropped
                                if (idx_q == 2'd1) start_q <= eep_rdata;
                            end
                            default: begin
                                page_q <= {page_q[23:0], eep_rdata};
                            end
                        endcase
                        if (rd_left_q == 8'h01) begin
                            st_q <= ECL_S_NEXT;
                        end else if (bst_left_q == 8'h01) begin
                            st_q <= ECL_S_REQ;
                        end
                    end
                end
                ECL_S_NEXT: begin
                    idx_q <= 2'd0;
                    case (ph_q)
                        ECL_PH_HDR: begin
                            hcrc_q <= crc_q;
                            ch_q <= 2'd0;
                            if (map_en && !slot_ok) begin
                                slot_err_q <= 1'b1;
                                load_busy <= 1'b0;
                                st_q <= ECL_S_IDLE;
                            end else begin
                                st_q <= ECL_S_CHAN;
                            end
                        end
                        ECL_PH_ENT: begin
                            // Zeroed or stray entries point into the index
                            if (start_q < data_min) begin
                                slot_err_q <= 1'b1;
                                load_busy <= 1'b0;
                                st_q <= ECL_S_IDLE;
                            end else begin
                                ph_q <= ECL_PH_DAT;
                                rd_addr_q <= start_q;
                                rd_left_q <= ECL_PAGE_LEN;
                                st_q <= ECL_S_REQ;
                            end
                        end
                        default: begin
                            shadow_q[ch_q] <= page_q;
                            if (crc_bad) begin
                                crc_err_q <= 1'b1;
                                load_busy <= 1'b0;
                                st_q <= ECL_S_IDLE;
                            end else if (last_ch) begin
                                st_q <= ECL_S_APPLY;
                            end else begin
                                ch_q <= ch_q + 2'd1;
                                st_q <= ECL_S_CHAN;
                            end
                        end
                    endcase
                end
                ECL_S_CHAN: begin
                    crc_q <= hcrc_q;
                    if (map_en) begin
                        ph_q <= ECL_PH_ENT;
                        rd_addr_q <= ent_addr;
                        rd_left_q <= ent_len;
                    end else begin
                        ph_q <= ECL_PH_DAT;
                        rd_addr_q <= raw_addr;
                        rd_left_q <= ECL_PAGE_LEN;
                    end
                    st_q <= ECL_S_REQ;
                end
                ECL_S_APPLY: begin
                    // Outputs change only here, after every page has passed
                    cfg_ch0 <= shadow_q[0];
                    cfg_ch1 <= com_en ? shadow_q[0] : shadow_q[1];
                    cfg_ch2 <= com_en ? shadow_q[0] : shadow_q[2];
                    cfg_ch3 <= com_en ? shadow_q[0] : shadow_q[3];
                    cfg_apply <= 1'b1;
                    done_q <= 1'b1;
                    load_busy <= 1'b0;
                    st_q <= ECL_S_IDLE;
                end
                default: begin
                    st_q <= ECL_S_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Checks
    sequence s_page_fail;
        st_q == ECL_S_NEXT && ph_q == ECL_PH_DAT && crc_bad;
    endsequence
    sequence s_page_pass;
        st_q == ECL_S_NEXT && ph_q == ECL_PH_DAT && !crc_bad && last_ch;
    endsequence

    chk_header_first: assert property (@(posedge clk) disable iff (!rstn)
        $rose(load_busy) |=> eep_req && eep_addr == ECL_HDR_ADDR && eep_len == ECL_HDR_LEN)
        else $error("first read is not the header");
    chk_burst_limit: assert property (@(posedge clk) disable iff (!rstn)
        eep_req && ph_q != ECL_PH_HDR |-> eep_len != 8'h00 && eep_len <= bst_max)
        else $error("burst longer than header limit");
    chk_crc_blocks: assert property (@(posedge clk) disable iff (!rstn)
        s_page_fail |=> crc_err_q && !load_busy ##1 !cfg_apply[*3])
        else $error("bad crc did not stop the load");
    chk_crc_off: assert property (@(posedge clk) disable iff (!rstn)
        st_q == ECL_S_NEXT && ph_q == ECL_PH_DAT && !crc_en |=> !crc_err_q)
        else $error("crc flagged while disabled");
    chk_raw_addr: assert property (@(posedge clk) disable iff (!rstn)
        eep_req && ph_q == ECL_PH_DAT && !map_en |-> 8'(eep_addr - raw_addr) < ECL_PAGE_LEN)
        else $error("unindexed page read at wrong address");
    chk_index_addr: assert property (@(posedge clk) disable iff (!rstn)
        eep_req && ph_q == ECL_PH_ENT |-> 8'(eep_addr - ent_addr) < ent_len)
        else $error("index entry read at wrong address");
    // Independent of the stride wires, so a broken block offset still shows
    chk_index_block: assert property (@(posedge clk) disable iff (!rstn)
        eep_req && ph_q == ECL_PH_ENT && !big_img |->
        8'(eep_addr - ECL_IDX_BASE - {1'b0, 4'(sa_q - ECL_SA_MIN), 3'h0} - {5'h00, ch_q, 1'b0}) < ECL_ENT2_LEN)
        else $error("two-byte entry outside its slot block");
    chk_start_use: assert property (@(posedge clk) disable iff (!rstn)
        eep_req && ph_q == ECL_PH_DAT && map_en |-> 8'(eep_addr - start_q) < ECL_PAGE_LEN)
        else $error("page not read from entry start");
    chk_shared_page: assert property (@(posedge clk) disable iff (!rstn)
        cfg_apply && com_en |-> cfg_ch1 == cfg_ch0 && cfg_ch2 == cfg_ch0 && cfg_ch3 == cfg_ch0)
        else $error("shared page not copied to all channels");
    chk_apply_after: assert property (@(posedge clk) disable iff (!rstn)
        s_page_pass |=> ##1 cfg_apply && done_q)
        else $error("passing load did not apply");
endmodule
`default_nettype wire

// [ecl_eep_model.sv]
// EEPROM read engine model: answers each burst request with eep_len image bytes.
// Assumes the loader's clock; the testbench writes the image into mem directly.
`timescale 1ns/1ns
`default_nettype none
module ecl_eep_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic eep_req,
    input wire logic [7:0] eep_addr,
    input wire logic [7:0] eep_len,
    input wire logic slow,
    output logic eep_rvalid,
    output logic [7:0] eep_rdata,
    output logic eep_err,
    output logic [7:0] max_len
);
    // ========================================
    // Byte stream
    logic [7:0] mem [256];
    logic [7:0] ptr_q;
    logic [7:0] left_q;
    logic [7:0] last_q;
    logic [1:0] gap_q;
    assign eep_err = 1'b0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= 8'h00;
            left_q <= 8'h00;
            last_q <= 8'h00;
            gap_q <= 2'h0;
            max_len <= 8'h00;
            eep_rvalid <= 1'b0;
            eep_rdata <= 8'h00;
        end else begin
            eep_rvalid <= 1'b0;
            // Idle data never repeats the last byte, so a stale sample shows
            eep_rdata <= ~last_q;
            if (eep_req) begin
                ptr_q <= eep_addr;
                left_q <= eep_len;
                gap_q <= 2'h1;
                // Header burst is fixed at 3, so only later bursts are tracked
                if (eep_addr != 8'h00 && eep_len > max_len) begin
                    max_len <= eep_len;
                end
            end else if (left_q != 8'h00) begin
                if (gap_q != 2'h0) begin
                    gap_q <= gap_q - 2'h1;
                end else begin
                    eep_rvalid <= 1'b1;
                    eep_rdata <= mem[ptr_q];
                    last_q <= mem[ptr_q];
                    ptr_q <= ptr_q + 8'h01;
                    left_q <= left_q - 8'h01;
                    gap_q <= slow ? 2'h2 : 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench for the configuration image loader.
// Assumes the EEPROM model answers every burst; images are poked into it.
`timescale 1ns/1ns
`default_nettype none
module tb_top import ecl_pkg::*; ;
    // ========================================
    // Signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic slow = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic ack, req, rvalid, err, apply, busy;
    logic [7:0] eaddr, elen, rbyte, max_len;
    logic [31:0] cfg [4];
    logic [31:0] exp_cfg [4];
    logic [31:0] old [4];
    logic [6:0] sl;
    int mismatches = 0;
    int samples_checked = 0;
    int applies = 0;
    int n0;
    always #10 clk = ~clk;
    always @(posedge clk) if (apply === 1'b1) applies <= applies + 1;
    ecl_loader dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .eep_req(req), .eep_addr(eaddr), .eep_len(elen), .eep_rvalid(rvalid), .eep_rdata(rbyte),
        .eep_err(err), .cfg_ch0(cfg[0]), .cfg_ch1(cfg[1]), .cfg_ch2(cfg[2]), .cfg_ch3(cfg[3]),
        .cfg_apply(apply), .load_busy(busy));
    ecl_eep_model eep_u (.clk(clk), .rstn(rstn), .eep_req(req), .eep_addr(eaddr),
        .eep_len(elen), .slow(slow), .eep_rvalid(rvalid), .eep_rdata(rbyte), .eep_err(err),
        .max_len(max_len));
    // ========================================
    // Tasks
    task test_done();
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, want, got);
        end
    endtask
    task chk_cfg();
        for (int c = 0; c < 4; c++) chk("cfg", cfg[c], exp_cfg[c]);
    endtask
    // Classic single cycle; read data is taken at the ack edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) mismatches++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task idle();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) mismatches++;
        // One more edge lets the apply counter settle
        @(posedge clk);
    endtask
    task run(input logic [6:0] s);
        wb(1'b1, ECL_REG_CTRL, {17'h0, s, 8'h01});
        idle();
    endtask
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ ECL_CRC_POLY) : (r << 1);
        return r;
    endfunction
    task put(input logic [7:0] a, input logic [31:0] v);
        for (int i = 0; i < 4; i++) eep_u.mem[a + i] = v[31 - 8 * i -: 8];
    endtask
    task hdr(input logic [7:0] b0, input logic [7:0] b2);
        for (int i = 0; i < 256; i++) eep_u.mem[i] = 8'h00;
        eep_u.mem[0] = b0;
        eep_u.mem[1] = 8'h00;
        eep_u.mem[2] = b2;
    endtask
    // Two-byte entries only, so the index ends at 0x82 and data starts at 0x83
    task idx(input logic [6:0] s, input logic [7:0] b0, input int bad);
        logic [7:0] e, a, c;
        hdr(b0, 8'h10);
        for (int ch = 0; ch < 4; ch++) begin
            e = ECL_IDX_BASE + 8'((s - ECL_SA_MIN) * 8) + 8'(ch * 2);
            a = ECL_DATA2 + 8'(ch * 4);
            exp_cfg[ch] = {8'hA5, 1'b0, s, 8'h3C, 8'(ch)};
            put(a, exp_cfg[ch]);
            c = crc(crc(crc(crc(ECL_CRC_INIT, b0), 8'h00), 8'h10), a);
            for (int i = 0; i < 4; i++) c = crc(c, eep_u.mem[a + i]);
            eep_u.mem[e] = c ^ 8'(ch == bad);
            eep_u.mem[e + 1] = a;
        end
    endtask
    // ========================================
    // Tests
    initial begin
        hdr(8'h05, 8'h02);
        for (int c = 0; c < 4; c++) begin
            exp_cfg[c] = 32'h81261018 + {8'(c), 24'h0};
            put(8'h03 + 8'(c * 4), exp_cfg[c]);
        end
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        idle();
        chk_cfg();
        chk("burst", {24'h0, max_len}, 32'h2);
        wb(1'b0, ECL_REG_HDR, 32'h0);
        chk("hdr", q, 32'h00020005);
        wb(1'b0, ECL_REG_STAT, 32'h0);
        chk("stat", q, 32'h2);
        slow <= 1'b0;
        hdr(8'h10, 8'h10);
        put(8'h03, 32'h5A261018);
        for (int c = 0; c < 4; c++) exp_cfg[c] = 32'h5A261018;
        run(ECL_SA_MIN);
        chk_cfg();
        for (int k = 0; k < 3; k++) begin
            sl = ECL_SA_MIN + 7'(k == 2 ? 15 : k);
            idx(sl, 8'hC0, 9);
            n0 = applies;
            run(sl);
            chk_cfg();
            chk("apply", applies, n0 + 1);
        end
        old = exp_cfg;
        n0 = applies;
        idx(ECL_SA_MIN + 7'h1, 8'hC0, 2);
        exp_cfg = old;
        run(ECL_SA_MIN + 7'h1);
        chk_cfg();
        chk("apply", applies, n0);
        wb(1'b0, ECL_REG_STAT, 32'h0);
        chk("crc_err", {31'h0, q[2]}, 32'h1);
        idx(ECL_SA_MIN + 7'h1, 8'h40, 2);
        run(ECL_SA_MIN + 7'h1);
        chk_cfg();
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b0, ECL_REG_CTRL, 32'h0);
        chk("ctrl", q, 32'h00001900);
        // Slot address outside the indexed range aborts before any page is read
        n0 = applies;
        run(7'h28);
        chk_cfg();
        chk("apply", applies, n0);
        wb(1'b0, ECL_REG_STAT, 32'h0);
        chk("slot_err", q, 32'h10);
        test_done();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
